// *** inc/psr_defs.svh ***
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// register indices; byte address is four times the index
`define PSR_IDX_DRV_LO 16'hfa74
`define PSR_IDX_DRV_HI 16'hfa75
`define PSR_IDX_SLEW 16'hfa76
`define PSR_IDX_RGMII 16'hfa78
`define PSR_IDX_STRAP_LO 16'hfa80
`define PSR_IDX_STRAP_HI 16'hfa81

// reset values
`define PSR_RST_DRV_LO 15'h7fff
`define PSR_RST_DRV_HI 15'h0000
`define PSR_RST_SLEW 16'h0000
`define PSR_RST_RGMII 12'h000

// field layout
`define PSR_G2_SUPPLY 15
`define PSR_RG_TX_PU 11
`define PSR_RG_TX_PD 10
`define PSR_RG_RX_PU 9
`define PSR_RG_RX_PD 8
`define PSR_RG_TX_VOL 5
`define PSR_RG_RX_VOL 4
`define PSR_RG_TXD_SLOW 3
`define PSR_RG_TXC_SLOW 2
`define PSR_RG_RXD_SLOW 1
`define PSR_RG_RXC_SLOW 0
`define PSR_RG_MASK 12'hf3f

// bus responses
`define PSR_RESP_OKAY 2'b00
`define PSR_RESP_SLVERR 2'b10

`endif

// *** inc/psr_pkg.sv ***
package psr_pkg;

   typedef enum logic [1:0]
   {
      PSR_ST_SYNC1 = 2'b00,
      PSR_ST_SYNC2 = 2'b01,
      PSR_ST_CAPT = 2'b10,
      PSR_ST_RUN = 2'b11
   } psr_strap_state_t;

   typedef enum logic [2:0]
   {
      PSR_SEL_NONE = 3'b000,
      PSR_SEL_DRV_LO = 3'b001,
      PSR_SEL_DRV_HI = 3'b010,
      PSR_SEL_SLEW = 3'b011,
      PSR_SEL_RGMII = 3'b100,
      PSR_SEL_STRAP_LO = 3'b101,
      PSR_SEL_STRAP_HI = 3'b110
   } psr_sel_t;

endpackage : psr_pkg

// *** src/psr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module psr_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++)
      begin : g_bit
         always_ff @(posedge clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end
            else
            begin
               meta_ff[gi] <= async_i[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;

endmodule : psr_sync

`default_nettype wire

// *** src/psr_regs.sv ***
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "psr_defs.svh"

module psr_regs
   import psr_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int G2_PINS = 15,
   parameter int STRAP_LO_W = 14,
   parameter int STRAP_HI_W = 15
)
(
   // clock and resets
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic soft_rst_i,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // strap pins
   input wire logic [STRAP_LO_W-1:0] strap_lo_pins_i,
   input wire logic [STRAP_HI_W-1:0] strap_hi_pins_i,
   // group-two pad controls
   output logic [G2_PINS-1:0] group2_drive_strength_lo_o,
   output logic [G2_PINS-1:0] group2_drive_strength_hi_o,
   output logic [G2_PINS-1:0] group_two_pin_bits_fast_o,
   output logic group_supply_select_o,
   // rgmii pad controls
   output logic tx_pullup_enable_o,
   output logic tx_pulldown_enable_o,
   output logic rx_pullup_enable_o,
   output logic rx_pulldown_enable_o,
   output logic tx_supply_select_o,
   output logic rx_supply_select_o,
   output logic tx_data_slow_slew_o,
   output logic tx_clock_slow_slew_o,
   output logic rx_data_slow_slew_o,
   output logic rx_clock_slow_slew_o,
   // captured straps
   output logic [STRAP_LO_W-1:0] strap_bits_lo_o,
   output logic [STRAP_HI_W-1:0] strap_bits_hi_o
);

   function automatic psr_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [15:0] idx;
      idx = 16'(addr[ADDR_W-1:2]);
      case (idx)
         `PSR_IDX_DRV_LO: decode = PSR_SEL_DRV_LO;
         `PSR_IDX_DRV_HI: decode = PSR_SEL_DRV_HI;
         `PSR_IDX_SLEW: decode = PSR_SEL_SLEW;
         `PSR_IDX_RGMII: decode = PSR_SEL_RGMII;
         `PSR_IDX_STRAP_LO: decode = PSR_SEL_STRAP_LO;
         `PSR_IDX_STRAP_HI: decode = PSR_SEL_STRAP_HI;
         default: decode = PSR_SEL_NONE;
      endcase
   endfunction : decode

   // merges the two low byte lanes; registers are 16 bits at most
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0])
      begin
         res[7:0] = wd[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = wd[15:8];
      end
      merge = res;
   endfunction : merge

   // bus state
   logic aw_held_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic w_held_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic nxt_aw_held;
   logic nxt_w_held;
   logic nxt_rvalid;
   logic wr_fire;
   logic rd_take;
   psr_sel_t wr_sel;
   psr_sel_t rd_sel;

   // register contents
   logic [G2_PINS-1:0] drv_lo_ff;
   logic [G2_PINS-1:0] drv_hi_ff;
   logic [15:0] slew_ff;
   logic [11:0] rgmii_ff;
   logic [STRAP_LO_W-1:0] strap_lo_ff;
   logic [STRAP_HI_W-1:0] strap_hi_ff;
   logic [STRAP_LO_W-1:0] strap_lo_sync;
   logic [STRAP_HI_W-1:0] strap_hi_sync;
   psr_strap_state_t state_ff;
   psr_strap_state_t nxt_state;
   logic [15:0] rd_word;

   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign rd_take = s_axi_arvalid_i && arready_ff;
   assign wr_sel = decode(aw_addr_ff);
   assign rd_sel = decode(s_axi_araddr_i);

   always_comb
   begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_rvalid = rvalid_ff;
      if (s_axi_awvalid_i && awready_ff)
      begin
         nxt_aw_held = 1'b1;
      end
      else if (wr_fire)
      begin
         nxt_aw_held = 1'b0;
      end
      if (s_axi_wvalid_i && wready_ff)
      begin
         nxt_w_held = 1'b1;
      end
      else if (wr_fire)
      begin
         nxt_w_held = 1'b0;
      end
      if (rd_take)
      begin
         nxt_rvalid = 1'b1;
      end
      else if (s_axi_rready_i)
      begin
         nxt_rvalid = 1'b0;
      end
   end

   // address and data may arrive in either order; each is parked until both are here
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
      end
      else
      begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awready_ff <= !nxt_aw_held;
         wready_ff <= !nxt_w_held;
         if (s_axi_awvalid_i && awready_ff)
         begin
            aw_addr_ff <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && wready_ff)
         begin
            w_data_ff <= s_axi_wdata_i;
            w_strb_ff <= s_axi_wstrb_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `PSR_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wr_sel == PSR_SEL_NONE) ? `PSR_RESP_SLVERR : `PSR_RESP_OKAY;
      end
      else if (s_axi_bready_i)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   // configuration registers; software reset loads their reset values like the hardware reset
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         drv_lo_ff <= `PSR_RST_DRV_LO;
         drv_hi_ff <= `PSR_RST_DRV_HI;
         slew_ff <= `PSR_RST_SLEW;
         rgmii_ff <= `PSR_RST_RGMII;
      end
      else if (soft_rst_i)
      begin
         drv_lo_ff <= `PSR_RST_DRV_LO;
         drv_hi_ff <= `PSR_RST_DRV_HI;
         slew_ff <= `PSR_RST_SLEW;
         rgmii_ff <= `PSR_RST_RGMII;
      end
      else if (wr_fire)
      begin
         case (wr_sel)
            PSR_SEL_DRV_LO: drv_lo_ff <= G2_PINS'(merge(16'(drv_lo_ff), w_data_ff, w_strb_ff));
            PSR_SEL_DRV_HI: drv_hi_ff <= G2_PINS'(merge(16'(drv_hi_ff), w_data_ff, w_strb_ff));
            PSR_SEL_SLEW: slew_ff <= merge(slew_ff, w_data_ff, w_strb_ff);
            PSR_SEL_RGMII: rgmii_ff <= 12'(merge(16'(rgmii_ff), w_data_ff, w_strb_ff)) & `PSR_RG_MASK;
            default:
            begin
               drv_lo_ff <= drv_lo_ff;
            end
         endcase
      end
   end

   psr_sync #(.W(STRAP_LO_W)) u_sync_lo
   (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(strap_lo_pins_i),
      .sync_o(strap_lo_sync)
   );

   psr_sync #(.W(STRAP_HI_W)) u_sync_hi
   (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(strap_hi_pins_i),
      .sync_o(strap_hi_sync)
   );

   // the pins need two edges through the synchroniser before they are taken
   always_comb
   begin
      case (state_ff)
         PSR_ST_SYNC1: nxt_state = PSR_ST_SYNC2;
         PSR_ST_SYNC2: nxt_state = PSR_ST_CAPT;
         PSR_ST_CAPT: nxt_state = PSR_ST_RUN;
         PSR_ST_RUN: nxt_state = PSR_ST_RUN;
         default: nxt_state = PSR_ST_SYNC1;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff <= PSR_ST_SYNC1;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // straps ignore soft_rst_i on purpose; only the hardware reset release reloads them
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         strap_lo_ff <= '0;
         strap_hi_ff <= '0;
      end
      else if (state_ff == PSR_ST_CAPT)
      begin
         strap_lo_ff <= strap_lo_sync;
         strap_hi_ff <= strap_hi_sync;
      end
      else if (wr_fire && wr_sel == PSR_SEL_STRAP_LO)
      begin
         strap_lo_ff <= STRAP_LO_W'(merge(16'(strap_lo_ff), w_data_ff, w_strb_ff));
      end
      else if (wr_fire && wr_sel == PSR_SEL_STRAP_HI)
      begin
         strap_hi_ff <= STRAP_HI_W'(merge(16'(strap_hi_ff), w_data_ff, w_strb_ff));
      end
   end

   always_comb
   begin
      case (rd_sel)
         PSR_SEL_DRV_LO: rd_word = 16'(drv_lo_ff);
         PSR_SEL_DRV_HI: rd_word = 16'(drv_hi_ff);
         PSR_SEL_SLEW: rd_word = slew_ff;
         PSR_SEL_RGMII: rd_word = 16'(rgmii_ff);
         PSR_SEL_STRAP_LO: rd_word = 16'(strap_lo_ff);
         PSR_SEL_STRAP_HI: rd_word = 16'(strap_hi_ff);
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `PSR_RESP_OKAY;
      end
      else
      begin
         arready_ff <= !nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         if (rd_take)
         begin
            rdata_ff <= {16'h0000, rd_word};
            rresp_ff <= (rd_sel == PSR_SEL_NONE) ? `PSR_RESP_SLVERR : `PSR_RESP_OKAY;
         end
      end
   end

   assign s_axi_awready_o = awready_ff;
   assign s_axi_wready_o = wready_ff;
   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_arready_o = arready_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;

   // pad controls are the register flip-flops themselves
   assign group2_drive_strength_lo_o = drv_lo_ff;
   assign group2_drive_strength_hi_o = drv_hi_ff;
   assign group_two_pin_bits_fast_o = slew_ff[G2_PINS-1:0];
   assign group_supply_select_o = slew_ff[`PSR_G2_SUPPLY];
   assign tx_pullup_enable_o = rgmii_ff[`PSR_RG_TX_PU];
   assign tx_pulldown_enable_o = rgmii_ff[`PSR_RG_TX_PD];
   assign rx_pullup_enable_o = rgmii_ff[`PSR_RG_RX_PU];
   assign rx_pulldown_enable_o = rgmii_ff[`PSR_RG_RX_PD];
   assign tx_supply_select_o = rgmii_ff[`PSR_RG_TX_VOL];
   assign rx_supply_select_o = rgmii_ff[`PSR_RG_RX_VOL];
   assign tx_data_slow_slew_o = rgmii_ff[`PSR_RG_TXD_SLOW];
   assign tx_clock_slow_slew_o = rgmii_ff[`PSR_RG_TXC_SLOW];
   assign rx_data_slow_slew_o = rgmii_ff[`PSR_RG_RXD_SLOW];
   assign rx_clock_slow_slew_o = rgmii_ff[`PSR_RG_RXC_SLOW];
   assign strap_bits_lo_o = strap_lo_ff;
   assign strap_bits_hi_o = strap_hi_ff;

   cfg_soft_clear_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         soft_rst_i |=> (drv_hi_ff == 15'h0000) && (slew_ff == 16'h0000) && (rgmii_ff == 12'h000))
      else $error("config registers not cleared by reset");

   drive_lo_ones_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         soft_rst_i |=> group2_drive_strength_lo_o == 15'h7fff)
      else $error("lower drive bits not all ones after reset");

   strap_capture_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (state_ff == PSR_ST_CAPT) |=> (strap_bits_lo_o == $past(strap_lo_sync))
                                        && (strap_bits_hi_o == $past(strap_hi_sync)))
      else $error("strap pins not captured");

   strap_keep_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (state_ff == PSR_ST_RUN && !wr_fire) |=> $stable(strap_lo_ff) && $stable(strap_hi_ff))
      else $error("strap register changed without write");

   g2_supply_write_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (wr_fire && wr_sel == PSR_SEL_SLEW && w_strb_ff[1] && !soft_rst_i)
         |=> group_supply_select_o == $past(w_data_ff[15]))
      else $error("group supply select not written");

   tx_pull_write_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (wr_fire && wr_sel == PSR_SEL_RGMII && w_strb_ff[1] && !soft_rst_i)
         |=> tx_pullup_enable_o == $past(w_data_ff[11]) && tx_pulldown_enable_o == $past(w_data_ff[10]))
      else $error("tx pull enables not written");

   rgmii_slew_write_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (wr_fire && wr_sel == PSR_SEL_RGMII && w_strb_ff[0] && !soft_rst_i)
         |=> {tx_data_slow_slew_o, tx_clock_slow_slew_o, rx_data_slow_slew_o, rx_clock_slow_slew_o}
             == $past(w_data_ff[3:0]))
      else $error("rgmii slew bits not written");

   rsvd_read_zero_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         (rd_take && rd_sel == PSR_SEL_RGMII) |=> (s_axi_rdata_o & 32'hffff_f0c0) == 32'h0000_0000)
      else $error("reserved bits not zero");

   write_resp_a:
      assert property (@(posedge clk_i) disable iff (!nrst_i)
         wr_fire |=> s_axi_bvalid_o ##0 (s_axi_bresp_o == `PSR_RESP_OKAY) == ($past(wr_sel) != PSR_SEL_NONE))
      else $error("write response wrong");

endmodule : psr_regs

`default_nettype wire

// *** verif/pad_config_and_strap_regs_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "psr_defs.svh"

module pad_config_and_strap_regs_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic soft_rst = 1'b0;
   logic [17:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [17:0] araddr = '0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [13:0] lo_pins = 14'h2a5c;
   logic [14:0] hi_pins = 15'h5a3c;
   logic awready, wready, bvalid, arready, rvalid, supply;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [14:0] drv_lo, drv_hi, fast, st_hi;
   logic [13:0] st_lo;
   logic tx_pu, tx_pd, rx_pu, rx_pd, tx_vol, rx_vol, txd, txc, rxd, rxc;
   logic [11:0] rg_view;
   int error_cnt = 0;
   int n_compared = 0;

   assign rg_view = {tx_pu, tx_pd, rx_pu, rx_pd, 2'b00, tx_vol, rx_vol, txd, txc, rxd, rxc};

   always #2.5 clk = ~clk;

   psr_regs u_psr_regs
   (
      .clk_i(clk), .nrst_i(nrst), .soft_rst_i(soft_rst),
      .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .strap_lo_pins_i(lo_pins), .strap_hi_pins_i(hi_pins),
      .group2_drive_strength_lo_o(drv_lo), .group2_drive_strength_hi_o(drv_hi),
      .group_two_pin_bits_fast_o(fast), .group_supply_select_o(supply),
      .tx_pullup_enable_o(tx_pu), .tx_pulldown_enable_o(tx_pd),
      .rx_pullup_enable_o(rx_pu), .rx_pulldown_enable_o(rx_pd),
      .tx_supply_select_o(tx_vol), .rx_supply_select_o(rx_vol),
      .tx_data_slow_slew_o(txd), .tx_clock_slow_slew_o(txc),
      .rx_data_slow_slew_o(rxd), .rx_clock_slow_slew_o(rxc),
      .strap_bits_lo_o(st_lo), .strap_bits_hi_o(st_hi)
   );

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // ready and valid are registered, so sampling them at the negedge gives the value seen at the next posedge
   task automatic wr(input logic [15:0] idx, input logic [31:0] data, input logic [3:0] strb,
                     input logic [1:0] exp_resp);
      logic aw_p, w_p, aw_hs, w_hs, b_hs;
      logic [1:0] resp;
      int n;
      aw_p = 1'b1;
      w_p = 1'b1;
      b_hs = 1'b0;
      n = 0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= data;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_hs && n < 50)
      begin
         @(negedge clk);
         aw_hs = aw_p && (awready === 1'b1);
         w_hs = w_p && (wready === 1'b1);
         b_hs = (bvalid === 1'b1);
         resp = bresp;
         @(posedge clk);
         if (aw_hs)
         begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_hs)
         begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
         if (b_hs)
            bready <= 1'b0;
         n++;
      end
      check("write response", {30'h0, exp_resp}, b_hs ? {30'h0, resp} : 32'hdead);
   endtask : wr

   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] exp_resp);
      logic ar_hs, r_hs;
      logic [31:0] data;
      logic [1:0] resp;
      int n;
      r_hs = 1'b0;
      ar_hs = 1'b0;
      n = 0;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_hs && n < 50)
      begin
         @(negedge clk);
         ar_hs = (arvalid === 1'b1) && (arready === 1'b1);
         r_hs = (rvalid === 1'b1);
         data = rdata;
         resp = rresp;
         @(posedge clk);
         if (ar_hs)
            arvalid <= 1'b0;
         if (r_hs)
            rready <= 1'b0;
         n++;
      end
      check("read data", exp, r_hs ? data : ~exp);
      check("read response", {30'h0, exp_resp}, r_hs ? {30'h0, resp} : 32'hdead);
   endtask : rd_chk

   task automatic chk_cfg(input logic [14:0] lo, input logic [14:0] hi, input logic [15:0] sl,
                          input logic [11:0] rg);
      @(negedge clk);
      check("drive low view", {17'h0, lo}, {17'h0, drv_lo});
      check("drive high view", {17'h0, hi}, {17'h0, drv_hi});
      check("slew view", {16'h0, sl}, {16'h0, supply, fast});
      check("rgmii view", {20'h0, rg}, {20'h0, rg_view});
   endtask : chk_cfg

   task automatic pulse_soft();
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
   endtask : pulse_soft

   initial
   begin
      #100000;
      error_cnt++;
      $display("MISMATCH watchdog expected done seen timeout");
      report_and_stop();
   end

   initial
   begin
      logic [31:0] one_hot;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // straps land three edges after release, wait one more
      repeat (4) @(posedge clk);
      chk_cfg(15'h7fff, 15'h0000, 16'h0000, 12'h000);
      rd_chk(`PSR_IDX_DRV_LO, 32'h7fff, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_DRV_HI, 32'h0000, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_SLEW, 32'h0000, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_RGMII, 32'h0000, `PSR_RESP_OKAY);
      check("strap low view", 32'h2a5c, {18'h0, st_lo});
      rd_chk(`PSR_IDX_STRAP_LO, 32'h2a5c, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_HI, 32'h5a3c, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_LO, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_HI, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_SLEW, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_RGMII, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_DRV_LO, 32'h7fff, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_DRV_HI, 32'h7fff, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_SLEW, 32'hffff, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_RGMII, 32'h0f3f, `PSR_RESP_OKAY);
      chk_cfg(15'h7fff, 15'h7fff, 16'hffff, 12'hf3f);
      // pin 0 code 11, pin 1 code 01, pin 2 code 10, rest 00
      wr(`PSR_IDX_DRV_LO, 32'h0000_0003, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_HI, 32'h0000_0005, 4'hf, `PSR_RESP_OKAY);
      chk_cfg(15'h0003, 15'h0005, 16'hffff, 12'hf3f);
      wr(`PSR_IDX_SLEW, 32'h0000_8000, 4'hf, `PSR_RESP_OKAY);
      chk_cfg(15'h0003, 15'h0005, 16'h8000, 12'hf3f);
      wr(`PSR_IDX_SLEW, 32'h0000_0001, 4'hf, `PSR_RESP_OKAY);
      chk_cfg(15'h0003, 15'h0005, 16'h0001, 12'hf3f);
      for (int i = 0; i < 12; i++)
      begin
         one_hot = 32'h1 << i;
         if (((`PSR_RG_MASK >> i) & 12'h001) != 12'h000)
         begin
            wr(`PSR_IDX_RGMII, one_hot, 4'hf, `PSR_RESP_OKAY);
            rd_chk(`PSR_IDX_RGMII, one_hot, `PSR_RESP_OKAY);
            @(negedge clk);
            check("rgmii one-hot view", one_hot, {20'h0, rg_view});
         end
      end
      // byte lanes: only lanes 0 and 1 carry register bits
      wr(`PSR_IDX_DRV_HI, 32'h0000_4321, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_HI, 32'h0000_00a5, 4'h1, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_DRV_HI, 32'h43a5, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_HI, 32'hffff_7e00, 4'h2, `PSR_RESP_OKAY);
      wr(`PSR_IDX_DRV_HI, 32'h1234_5678, 4'hc, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_DRV_HI, 32'h7ea5, `PSR_RESP_OKAY);
      // unmapped index between slew and rgmii control
      wr(16'hfa77, 32'hffff_ffff, 4'hf, `PSR_RESP_SLVERR);
      rd_chk(16'hfa77, 32'h0000, `PSR_RESP_SLVERR);
      chk_cfg(15'h0003, 15'h7ea5, 16'h0001, 12'h800);
      pulse_soft();
      chk_cfg(15'h7fff, 15'h0000, 16'h0000, 12'h000);
      rd_chk(`PSR_IDX_STRAP_LO, 32'h2a5c, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_HI, 32'h5a3c, `PSR_RESP_OKAY);
      wr(`PSR_IDX_STRAP_LO, 32'h0000_1111, 4'hf, `PSR_RESP_OKAY);
      wr(`PSR_IDX_STRAP_HI, 32'h0000_2222, 4'hf, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_LO, 32'h1111, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_HI, 32'h2222, `PSR_RESP_OKAY);
      // new pin levels must not leak in until the next hardware reset
      lo_pins <= 14'h15a3;
      hi_pins <= 15'h25c3;
      pulse_soft();
      rd_chk(`PSR_IDX_STRAP_LO, 32'h1111, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_HI, 32'h2222, `PSR_RESP_OKAY);
      wr(`PSR_IDX_RGMII, 32'h0000_0f3f, 4'hf, `PSR_RESP_OKAY);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      chk_cfg(15'h7fff, 15'h0000, 16'h0000, 12'h000);
      rd_chk(`PSR_IDX_STRAP_LO, 32'h15a3, `PSR_RESP_OKAY);
      rd_chk(`PSR_IDX_STRAP_HI, 32'h25c3, `PSR_RESP_OKAY);
      check("strap high view", 32'h25c3, {17'h0, st_hi});
      report_and_stop();
   end
endmodule : pad_config_and_strap_regs_tb_top

`default_nettype wire
